/* rtl/pod_regs.svh */
// register offsets, field positions, reset values and timing figures of the pwm output stage
`ifndef POD_REGS_SVH
`define POD_REGS_SVH
// ****************************************
// register word addresses
// ****************************************
`define POD_ADDR_CTRL_A 4'h0
`define POD_ADDR_CTRL_B 4'h1
`define POD_ADDR_DT_VALUE 4'h2
`define POD_ADDR_DT_SEL 4'h3
`define POD_ADDR_OVERRIDE 4'h4
`define POD_ADDR_CONFIG 4'h5
`define POD_ADDR_DUTY1 4'h6
`define POD_ADDR_STATUS 4'hA
// ****************************************
// field positions
// ****************************************
`define POD_CTRLA_MODE_LSB 0
`define POD_CTRLA_EN_LSB 4
`define POD_CTRLB_IUE_BIT 0
`define POD_CTRLB_OVERRIDE_SYNC_EN_BIT 1
`define POD_DTV_A_LSB 0
`define POD_DTV_B_LSB 8
`define POD_CFG_HIGH_SIDE_POLARITY_BIT 0
`define POD_CFG_LOW_SIDE_POLARITY_BIT 1
`define POD_CFG_PIN_BIT 2
// ****************************************
// reset values
// ****************************************
`define POD_RST_WORD 16'h0000
`define POD_RST_CFG 3'h7
`define POD_PAIRS_ALL_ON 4'hF
`define POD_PAIRS_ALL_OFF 4'h0
// ****************************************
// dead-time prescaler terminal counts (tcy, 2, 4, 8)
// ****************************************
`define POD_PRE_DIV1 3'h0
`define POD_PRE_DIV2 3'h1
`define POD_PRE_DIV4 3'h3
`define POD_PRE_DIV8 3'h7
`endif

/* rtl/pod_pkg.sv */
// types shared by the pwm output stage
package pod_pkg;
	// ****************************************
	// time-base modes, gray order along the usual path
	// ****************************************
	typedef enum logic [1:0] {
		POD_TB_FREE = 2'h0,
		POD_TB_UPDOWN = 2'h1,
		POD_TB_DOUBLE = 2'h3,
		POD_TB_SINGLE = 2'h2
	} pod_tbmode_t;
	// ****************************************
	// one dead-time setting: prescaler and count
	// ****************************************
	typedef struct packed {
		logic [1:0] prescale;
		logic [5:0] count;
	} pod_dt_t;
	// ****************************************
	// per-pair override selection and forced state
	// ****************************************
	typedef struct packed {
		logic selHigh;
		logic selLow;
		logic stateHigh;
		logic stateLow;
	} pod_ovr_t;
endpackage : pod_pkg

/* rtl/pod_output_stage.sv */
// pwm output stage: duty compare, pair modes, dead time, override and pin control
`include "pod_regs.svh"

// ****************************************
// dead-time unit of one complementary pair
// ****************************************
module pod_deadtime_unit import pod_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic highIn,
	input wire logic lowIn,
	input wire pod_dt_t dtA,
	input wire pod_dt_t dtB,
	input wire logic selActive,
	input wire logic selInactive,
	input wire logic clearPrescale,
	output logic highOut,
	output logic lowOut,
	output logic busy
);
	logic highPrev_q, highPrev_d;
	logic [5:0] count_q, count_d;
	logic [2:0] pre_q, pre_d;
	logic [1:0] ps_q, ps_d;
	logic rise, fall, tick;
	logic [2:0] preLast;
	pod_dt_t pick;

	// ****************************************
	// next state of the dead-time counter
	// ****************************************
	// edge detect, value pick and down count
	always_comb begin
		rise = highIn & ~highPrev_q;
		fall = ~highIn & highPrev_q;
		pick = (rise ? selActive : selInactive) ? dtB : dtA;
		case (ps_q)
			2'h0: preLast = `POD_PRE_DIV1;
			2'h1: preLast = `POD_PRE_DIV2;
			2'h2: preLast = `POD_PRE_DIV4;
			default: preLast = `POD_PRE_DIV8;
		endcase
		tick = (pre_q == preLast);
		highPrev_d = highIn;
		count_d = count_q;
		pre_d = pre_q;
		ps_d = ps_q;
		if (rise | fall) begin
			count_d = pick.count;
			ps_d = pick.prescale;
			pre_d = 3'h0;
		end else if (clearPrescale) begin
			pre_d = 3'h0;
		end else if (count_q != 6'h00) begin
			if (tick) begin
				pre_d = 3'h0;
				count_d = count_q - 6'h01;
			end else begin
				pre_d = pre_q + 3'h1;
			end
		end
	end

	// ****************************************
	// pin gating while the counter runs
	// ****************************************
	// turn-on of either pin waits for the counter to run out
	always_comb begin
		busy = (count_q != 6'h00) | rise | fall;
		highOut = highIn & ~busy;
		lowOut = lowIn & ~highIn & ~busy;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			highPrev_q <= 1'b0;
			count_q <= 6'h00;
			pre_q <= 3'h0;
			ps_q <= 2'h0;
		end else begin
			highPrev_q <= highPrev_d;
			count_q <= count_d;
			pre_q <= pre_d;
			ps_q <= ps_d;
		end
	end
endmodule // pod_deadtime_unit

// Notes on behaviour
// - immediate-update bit makes duty writes take effect
// - lowered duty below counter ends pulse early
// - raised duty above counter lengthens active pulse
// - inactive output with larger duty goes active
// - duty register n drives pair n, complementary
// - cleared mode bit means complementary; reset default
// - per-pair 6-bit dead-time counter on compare edges
// - active-edge and inactive-edge dead-time select bits
// - each value has prescaler of 1,2,4,8 cycles
// - two 6-bit counts times prescaled period
// - prescalers clear on load, dead-time writes, reset
// - independent pair: no dead time, both active
// - independent pins show pwm or forced state
// - single-pulse: active on enable, inactive on match
// - period match ends single pulse, requests stop
// - override upper byte selects, lower byte states
// - overridden low is complement; dead time kept
// - synced overrides act at zero, centre also period
// - reset pin strap: driven inactive or tri-stated; when driven, only the high pins start inactive, the low pins start active
// - separate polarity for high and low pins
// - strap and polarity combine with pair enables
// - edge-aligned: active from zero until duty match
// - duty buffered, compare value loaded at boundary
module pod_output_stage import pod_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [15:0] regRdData,
	input wire logic [14:0] timebaseCounter,
	input wire logic periodMatch,
	input wire logic counterZero,
	input wire logic timebaseEnable,
	input wire logic [1:0] timebaseMode,
	input wire logic highPolStrap,
	input wire logic lowPolStrap,
	input wire logic resetPinStrap,
	output logic [3:0] pairHighOut,
	output logic [3:0] pairHighOe,
	output logic [3:0] pairLowOut,
	output logic [3:0] pairLowOe,
	output logic singlePulseEnd
);
	// ****************************************
	// software registers
	// ****************************************
	logic [3:0] pairIndependentSel_q, pairIndependentSel_d;
	logic [3:0] pairOutputEnable_q, pairOutputEnable_d;
	logic immediateUpdateEn_q, immediateUpdateEn_d;
	logic overrideSyncEn_q, overrideSyncEn_d;
	logic [15:0] deadtimeValueReg_q, deadtimeValueReg_d;
	logic [7:0] deadtimeSelectReg_q, deadtimeSelectReg_d;
	logic [15:0] overrideControlReg_q, overrideControlReg_d;
	logic [15:0] dutyBuf_q [4];
	logic [15:0] dutyBuf_d [4];
	logic [15:0] dutyActive_q [4];
	logic [15:0] dutyActive_d [4];
	logic [15:0] regRdData_d;
	logic wrDuty, boundary, centre, single;
	logic [3:0] dutyIdx;
	pod_tbmode_t mode;

	// ****************************************
	// configuration caught after reset release
	// ****************************************
	logic [2:0] cfg_q, cfg_d;
	logic init_q;
	logic highPol, lowPol;

	// ****************************************
	// override, compare and pin state
	// ****************************************
	logic [15:0] overrideEff_d, overrideEff_q;
	logic [3:0] compare, busy;
	logic [3:0] dtHighIn, dtLowIn, dtHighOut, dtLowOut;
	logic [3:0] highActive, lowActive;
	logic [3:0] pairHighOut_d, pairLowOut_d, pairHighOe_d, pairLowOe_d;
	logic singlePulseEnd_d;
	pod_ovr_t ovr [4];

	// ****************************************
	// time-base decode
	// ****************************************
	// time-base mode decode and duty update boundary
	always_comb begin
		mode = pod_tbmode_t'(timebaseMode);
		single = (mode == POD_TB_SINGLE);
		centre = (mode == POD_TB_UPDOWN) | (mode == POD_TB_DOUBLE);
		case (mode)
			POD_TB_FREE: boundary = periodMatch;
			POD_TB_SINGLE: boundary = periodMatch;
			POD_TB_UPDOWN: boundary = counterZero;
			POD_TB_DOUBLE: boundary = counterZero | periodMatch;
			default: boundary = 1'b0;
		endcase
		boundary = boundary | ~timebaseEnable;
		dutyIdx = regAddr - `POD_ADDR_DUTY1;
		wrDuty = regWrEn & (regAddr >= `POD_ADDR_DUTY1) & (regAddr < `POD_ADDR_STATUS);
	end

	// ****************************************
	// register file and duty buffers
	// ****************************************
	// register writes and duty buffering
	always_comb begin
		pairIndependentSel_d = pairIndependentSel_q;
		pairOutputEnable_d = pairOutputEnable_q;
		immediateUpdateEn_d = immediateUpdateEn_q;
		overrideSyncEn_d = overrideSyncEn_q;
		deadtimeValueReg_d = deadtimeValueReg_q;
		deadtimeSelectReg_d = deadtimeSelectReg_q;
		overrideControlReg_d = overrideControlReg_q;
		cfg_d = cfg_q;
		if (init_q) begin
			cfg_d = {resetPinStrap, lowPolStrap, highPolStrap};
			pairOutputEnable_d = resetPinStrap ? `POD_PAIRS_ALL_OFF : `POD_PAIRS_ALL_ON;
		end
		if (regWrEn) begin
			case (regAddr)
				`POD_ADDR_CTRL_A: begin
					pairIndependentSel_d = regWrData[`POD_CTRLA_MODE_LSB +: 4];
					pairOutputEnable_d = regWrData[`POD_CTRLA_EN_LSB +: 4];
				end
				`POD_ADDR_CTRL_B: begin
					immediateUpdateEn_d = regWrData[`POD_CTRLB_IUE_BIT];
					overrideSyncEn_d = regWrData[`POD_CTRLB_OVERRIDE_SYNC_EN_BIT];
				end
				`POD_ADDR_DT_VALUE: deadtimeValueReg_d = regWrData;
				`POD_ADDR_DT_SEL: deadtimeSelectReg_d = regWrData[7:0];
				`POD_ADDR_OVERRIDE: overrideControlReg_d = regWrData;
				default: ;
			endcase
		end
		for (int k = 0; k < 4; k++) begin
			dutyBuf_d[k] = dutyBuf_q[k];
			if (wrDuty && dutyIdx == 4'(k))
				dutyBuf_d[k] = regWrData;
			dutyActive_d[k] = boundary ? dutyBuf_d[k] : dutyActive_q[k];
			if (wrDuty && dutyIdx == 4'(k) && immediateUpdateEn_q)
				dutyActive_d[k] = regWrData;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// read data, one cycle after the strobe
	always_comb begin
		regRdData_d = `POD_RST_WORD;
		if (regRdEn) begin
			case (regAddr)
				`POD_ADDR_CTRL_A: regRdData_d = {8'h00, pairOutputEnable_q, pairIndependentSel_q};
				`POD_ADDR_CTRL_B: regRdData_d = {14'h0000, overrideSyncEn_q, immediateUpdateEn_q};
				`POD_ADDR_DT_VALUE: regRdData_d = deadtimeValueReg_q;
				`POD_ADDR_DT_SEL: regRdData_d = {8'h00, deadtimeSelectReg_q};
				`POD_ADDR_OVERRIDE: regRdData_d = overrideControlReg_q;
				`POD_ADDR_CONFIG: regRdData_d = {13'h0000, cfg_q};
				`POD_ADDR_STATUS: regRdData_d = {8'h00, compare, busy};
				default: begin
					if (regAddr >= `POD_ADDR_DUTY1 && regAddr < `POD_ADDR_STATUS)
						regRdData_d = dutyBuf_q[dutyIdx[1:0]];
				end
			endcase
		end
	end

	// ****************************************
	// output override
	// ****************************************
	// overrides copied to the working set, optionally on time-base events
	always_comb begin
		overrideEff_d = overrideEff_q;
		if (~overrideSyncEn_q | counterZero | (centre & periodMatch))
			overrideEff_d = overrideControlReg_q;
		for (int k = 0; k < 4; k++) begin
			ovr[k].selHigh = overrideEff_q[8 + 2 * k];
			ovr[k].selLow = overrideEff_q[9 + 2 * k];
			ovr[k].stateHigh = overrideEff_q[2 * k];
			ovr[k].stateLow = overrideEff_q[1 + 2 * k];
		end
	end

	// ****************************************
	// pin path
	// ****************************************
	// duty compare per pair and source of each pin
	always_comb begin
		// straps used directly in the capture cycle, so the first
		// value driven after reset already has the right sense
		highPol = init_q ? highPolStrap : cfg_q[`POD_CFG_HIGH_SIDE_POLARITY_BIT];
		lowPol = init_q ? lowPolStrap : cfg_q[`POD_CFG_LOW_SIDE_POLARITY_BIT];
		singlePulseEnd_d = single & timebaseEnable & periodMatch;
		for (int k = 0; k < 4; k++) begin
			compare[k] = ({1'b0, timebaseCounter} < dutyActive_q[k]);
			if (single)
				compare[k] = compare[k] & timebaseEnable & ~periodMatch;
			dtHighIn[k] = ovr[k].selHigh ? ovr[k].stateHigh : compare[k];
			dtLowIn[k] = ovr[k].selLow ? (ovr[k].stateLow & ~dtHighIn[k]) : ~dtHighIn[k];
			if (pairIndependentSel_q[k]) begin
				highActive[k] = dtHighIn[k];
				lowActive[k] = ovr[k].selLow ? ovr[k].stateLow : compare[k];
			end else begin
				highActive[k] = dtHighOut[k];
				lowActive[k] = dtLowOut[k];
			end
			pairHighOut_d[k] = highPol ? highActive[k] : ~highActive[k];
			pairLowOut_d[k] = lowPol ? lowActive[k] : ~lowActive[k];
			pairHighOe_d[k] = pairOutputEnable_q[k];
			pairLowOe_d[k] = pairOutputEnable_q[k];
		end
	end

	// ****************************************
	// dead-time generators
	// ****************************************
	// one dead-time unit per pair
	for (genvar g = 0; g < 4; g++) begin : gen_dt
		pod_deadtime_unit pod_deadtime_unit_inst (
			.ref_clk(ref_clk),
			.reset(reset),
			.highIn(dtHighIn[g]),
			.lowIn(dtLowIn[g]),
			.dtA(pod_dt_t'({deadtimeValueReg_q[7:6], deadtimeValueReg_q[`POD_DTV_A_LSB +: 6]})),
			.dtB(pod_dt_t'({deadtimeValueReg_q[15:14], deadtimeValueReg_q[`POD_DTV_B_LSB +: 6]})),
			.selActive(deadtimeSelectReg_q[2 * g]),
			.selInactive(deadtimeSelectReg_q[2 * g + 1]),
			.clearPrescale(regWrEn & ((regAddr == `POD_ADDR_DT_VALUE) | (regAddr == `POD_ADDR_DT_SEL))),
			.highOut(dtHighOut[g]),
			.lowOut(dtLowOut[g]),
			.busy(busy[g])
		);
	end

	// ****************************************
	// state registers
	// ****************************************
	// register all state; pins tri-stated while reset holds
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			init_q <= 1'b1;
			cfg_q <= `POD_RST_CFG;
			pairIndependentSel_q <= `POD_PAIRS_ALL_OFF;
			pairOutputEnable_q <= `POD_PAIRS_ALL_OFF;
			immediateUpdateEn_q <= 1'b0;
			overrideSyncEn_q <= 1'b0;
			deadtimeValueReg_q <= `POD_RST_WORD;
			deadtimeSelectReg_q <= 8'h00;
			overrideControlReg_q <= `POD_RST_WORD;
			overrideEff_q <= `POD_RST_WORD;
			for (int k = 0; k < 4; k++) begin
				dutyBuf_q[k] <= `POD_RST_WORD;
				dutyActive_q[k] <= `POD_RST_WORD;
			end
			regRdData <= `POD_RST_WORD;
			pairHighOut <= 4'h0;
			pairLowOut <= 4'h0;
			pairHighOe <= 4'h0;
			pairLowOe <= 4'h0;
			singlePulseEnd <= 1'b0;
		end else begin
			init_q <= 1'b0;
			cfg_q <= cfg_d;
			pairIndependentSel_q <= pairIndependentSel_d;
			pairOutputEnable_q <= pairOutputEnable_d;
			immediateUpdateEn_q <= immediateUpdateEn_d;
			overrideSyncEn_q <= overrideSyncEn_d;
			deadtimeValueReg_q <= deadtimeValueReg_d;
			deadtimeSelectReg_q <= deadtimeSelectReg_d;
			overrideControlReg_q <= overrideControlReg_d;
			overrideEff_q <= overrideEff_d;
			for (int k = 0; k < 4; k++) begin
				dutyBuf_q[k] <= dutyBuf_d[k];
				dutyActive_q[k] <= dutyActive_d[k];
			end
			regRdData <= regRdData_d;
			pairHighOut <= pairHighOut_d;
			pairLowOut <= pairLowOut_d;
			pairHighOe <= pairHighOe_d;
			pairLowOe <= pairLowOe_d;
			singlePulseEnd <= singlePulseEnd_d;
		end
	end
endmodule // pod_output_stage

/* test/pod_output_checker.sv */
// assertion checker bound to the pwm output stage ports
`include "pod_regs.svh"
module pod_output_checker import pod_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [15:0] regRdData,
	input wire logic periodMatch,
	input wire logic timebaseEnable,
	input wire logic [1:0] timebaseMode,
	input wire logic highPolStrap,
	input wire logic lowPolStrap,
	input wire logic resetPinStrap,
	input wire logic [3:0] pairHighOut,
	input wire logic [3:0] pairHighOe,
	input wire logic [3:0] pairLowOut,
	input wire logic [3:0] pairLowOe,
	input wire logic singlePulseEnd
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic [3:0] modeQ;
	logic [3:0] modeD;
	// mirror of the pair mode bits
	always_comb begin
		modeD = (regWrEn && regAddr == `POD_ADDR_CTRL_A) ? regWrData[3:0] : modeQ;
	end
	always_ff @(posedge ref_clk) begin
		modeQ <= reset ? 4'h0 : modeD;
	end
	property p_pins_after_reset;
		$fell(reset) |-> ##2 {pairHighOe, pairLowOe} == {8{!resetPinStrap}};
	endproperty
	a_pins_after_reset: assert property (p_pins_after_reset) else $error("pin enables wrong after reset");
	property p_no_overlap;
		((pairHighOut ~^ {4{highPolStrap}}) & (pairLowOut ~^ {4{lowPolStrap}}) & ~modeQ) == 4'h0;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both pins of a pair active");
	property p_sp_end;
		periodMatch && timebaseEnable && timebaseMode == POD_TB_SINGLE |=> singlePulseEnd;
	endproperty
	a_sp_end: assert property (p_sp_end) else $error("single pulse end missing");
	property p_sp_cause;
		singlePulseEnd |-> $past(periodMatch) && $past(timebaseEnable) && $past(timebaseMode) == 2'h2;
	endproperty
	a_sp_cause: assert property (p_sp_cause) else $error("single pulse end without cause");
	property p_sp_once;
		singlePulseEnd |=> !singlePulseEnd;
	endproperty
	a_sp_once: assert property (p_sp_once) else $error("single pulse end too long");
	property p_ovr_back;
		regWrEn && regAddr == `POD_ADDR_OVERRIDE ##2 regRdEn && regAddr == `POD_ADDR_OVERRIDE
			|=> regRdData == $past(regWrData, 3);
	endproperty
	a_ovr_back: assert property (p_ovr_back) else $error("override readback wrong");
	property p_dt_back;
		regWrEn && regAddr == `POD_ADDR_DT_VALUE ##2 regRdEn && regAddr == `POD_ADDR_DT_VALUE
			|=> regRdData == $past(regWrData, 3);
	endproperty
	a_dt_back: assert property (p_dt_back) else $error("dead-time readback wrong");
	property p_cfg_read;
		regRdEn && regAddr == `POD_ADDR_CONFIG |=> regRdData == {13'h0000, resetPinStrap, lowPolStrap, highPolStrap};
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
endmodule // pod_output_checker
bind pod_output_stage pod_output_checker pod_output_checker_inst (.ref_clk, .reset, .regAddr, .regWrData,
	.regWrEn, .regRdEn, .regRdData, .periodMatch, .timebaseEnable, .timebaseMode, .highPolStrap,
	.lowPolStrap, .resetPinStrap, .pairHighOut, .pairHighOe, .pairLowOut, .pairLowOe, .singlePulseEnd);

/* test/pod_switch_model.sv */
// gate driver model seen by the four pin pairs
module pod_switch_model (
	input wire logic ref_clk,
	input wire logic [3:0] pairHighOut,
	input wire logic [3:0] pairHighOe,
	input wire logic [3:0] pairLowOut,
	input wire logic [3:0] pairLowOe,
	output logic [3:0] gateHigh,
	output logic [3:0] gateLow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] lastHighQ = 4'h0;
	logic [3:0] lastLowQ = 4'h0;
	// released pins float and toggle every cycle
	assign gateHigh = (pairHighOut & pairHighOe) | (~lastHighQ & ~pairHighOe);
	assign gateLow = (pairLowOut & pairLowOe) | (~lastLowQ & ~pairLowOe);
	always @(posedge ref_clk) begin
		lastHighQ <= gateHigh;
		lastLowQ <= gateLow;
	end
endmodule // pod_switch_model

/* test/pwm_output_stage_deadtime_test.sv */
// self-checking bench of the pwm output stage
`include "pod_regs.svh"
module pwm_output_stage_deadtime_test import pod_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [15:0] regRdData;
	logic [14:0] timebaseCounter = 15'h0064;
	logic periodMatch = 1'b0;
	logic counterZero = 1'b0;
	logic timebaseEnable = 1'b0;
	logic [1:0] timebaseMode = POD_TB_FREE;
	logic highPolStrap = 1'b1;
	logic lowPolStrap = 1'b1;
	logic resetPinStrap = 1'b0;
	logic [3:0] pairHighOut, pairHighOe, pairLowOut, pairLowOe, gateHigh, gateLow;
	logic singlePulseEnd, spSeen;
	logic [1:0] prevP2 = 2'h0;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int offAt = 0;
	int onAt = 0;
	always #5 ref_clk = ~ref_clk;
	pod_output_stage pod_output_stage_inst (.ref_clk, .reset, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.regRdData, .timebaseCounter, .periodMatch, .counterZero, .timebaseEnable, .timebaseMode,
		.highPolStrap, .lowPolStrap, .resetPinStrap, .pairHighOut, .pairHighOe, .pairLowOut,
		.pairLowOe, .singlePulseEnd);
	pod_switch_model pod_switch_model_inst (.ref_clk, .pairHighOut, .pairHighOe, .pairLowOut,
		.pairLowOe, .gateHigh, .gateLow);
	// stamps the cycles at which the pins of pair 2 switch
	always @(posedge ref_clk) begin
		#1;
		cyc++;
		if ((prevP2 & ~{gateHigh[1], gateLow[1]}) != 2'h0) offAt = cyc;
		if ((~prevP2 & {gateHigh[1], gateLow[1]}) != 2'h0) onAt = cyc;
		prevP2 = {gateHigh[1], gateLow[1]};
	end
	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1 chk(regRdData, exp);
		@(posedge ref_clk);
	endtask
	task automatic pins(input logic [1:0] exp);
		repeat (2) @(posedge ref_clk);
		#1 chk({14'h0000, gateHigh[0], gateLow[0]}, {14'h0000, exp});
		@(posedge ref_clk);
	endtask
	task automatic pulse(input logic zero);
		counterZero <= zero;
		periodMatch <= !zero;
		@(posedge ref_clk);
		counterZero <= 1'b0;
		periodMatch <= 1'b0;
		#1 spSeen = singlePulseEnd;
		@(posedge ref_clk);
	endtask
	task automatic dtEdge(input logic [15:0] duty, input int exp);
		offAt = 0;
		onAt = 0;
		wr(`POD_ADDR_DUTY1 + 4'h1, duty);
		for (int n = 0; n < 300 && !(onAt > offAt && offAt > 0); n++) @(posedge ref_clk);
		if (!(onAt > offAt && offAt > 0)) begin
			chk(16'h0000, 16'h0001);
			conclude();
		end
		chk(16'(onAt - offAt), 16'(exp));
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({8'h00, pairHighOe, pairLowOe}, 16'h00FF);
		chk({12'h000, gateHigh}, 16'h0000);
		rd(`POD_ADDR_CTRL_A, 16'h00F0);
		rd(4'hF, 16'h0000);
		rd(`POD_ADDR_CONFIG, 16'h0003);
		chk({12'h000, gateLow}, 16'h000F);
		// dead time on pair 2 with the time base stopped
		wr(`POD_ADDR_DT_SEL, 16'h0004);
		for (int p = 0; p < 4; p++) begin
			wr(`POD_ADDR_DT_VALUE, {2'(p), 6'h02, 2'h1, 6'h03});
			rd(`POD_ADDR_DT_VALUE, {2'(p), 6'h02, 2'h1, 6'h03});
			dtEdge(16'h00C8, 2 * (1 << p) + 1);
			dtEdge(16'h0032, 7);
		end
		// immediate duty updates on independent pair 1
		timebaseEnable <= 1'b1;
		wr(`POD_ADDR_CTRL_A, 16'h00F1);
		wr(`POD_ADDR_CTRL_B, 16'h0001);
		wr(`POD_ADDR_DUTY1, 16'h00C8);
		pins(2'h3);
		wr(`POD_ADDR_DUTY1, 16'h012C);
		timebaseCounter <= 15'h00FA;
		pins(2'h3);
		wr(`POD_ADDR_DUTY1, 16'h0032);
		pins(2'h0);
		wr(`POD_ADDR_CTRL_B, 16'h0000);
		wr(`POD_ADDR_DUTY1, 16'h012C);
		pins(2'h0);
		pulse(1'b0);
		chk({15'h0000, spSeen}, 16'h0000);
		pins(2'h3);
		// overrides, direct then synced to counter zero and, in up/down mode, period match
		wr(`POD_ADDR_OVERRIDE, 16'h0302);
		rd(`POD_ADDR_OVERRIDE, 16'h0302);
		pins(2'h1);
		wr(`POD_ADDR_CTRL_B, 16'h0002);
		wr(`POD_ADDR_OVERRIDE, 16'h0301);
		pins(2'h1);
		pulse(1'b0);
		pins(2'h1);
		pulse(1'b1);
		pins(2'h2);
		timebaseMode <= POD_TB_UPDOWN;
		wr(`POD_ADDR_OVERRIDE, 16'h0302);
		pins(2'h2);
		pulse(1'b0);
		pins(2'h1);
		wr(`POD_ADDR_OVERRIDE, 16'h0000);
		pulse(1'b1);
		// single pulse on pair 1
		wr(`POD_ADDR_CTRL_B, 16'h0000);
		timebaseMode <= POD_TB_SINGLE;
		timebaseEnable <= 1'b0;
		wr(`POD_ADDR_DUTY1, 16'h0096);
		timebaseCounter <= 15'h000A;
		pins(2'h0);
		timebaseEnable <= 1'b1;
		pins(2'h3);
		timebaseCounter <= 15'h00A0;
		pins(2'h0);
		timebaseCounter <= 15'h000A;
		pins(2'h3);
		pulse(1'b0);
		chk({15'h0000, spSeen}, 16'h0001);
		timebaseEnable <= 1'b0;
		pins(2'h0);
		// second reset with pins tri-stated and inverted high side
		reset <= 1'b1;
		resetPinStrap <= 1'b1;
		highPolStrap <= 1'b0;
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({8'h00, pairHighOe, pairLowOe}, 16'h0000);
		chk({12'h000, pairHighOut}, 16'h000F);
		rd(`POD_ADDR_CTRL_A, 16'h0000);
		wr(`POD_ADDR_CONFIG, 16'h0000);
		rd(`POD_ADDR_CONFIG, 16'h0006);
		conclude();
	end
endmodule // pwm_output_stage_deadtime_test
